/* File: common/fesf_pkg.sv */
package fesf_pkg;

	typedef enum logic [1:0] {
		FESF_CMD_WRITE,
		FESF_CMD_READ,
		FESF_CMD_TOGGLE,
		FESF_CMD_DPOLL
	} fesf_cmd_t;

	typedef enum logic [1:0] {
		FESF_RES_OK,
		FESF_RES_FAIL,
		FESF_RES_ABORT,
		FESF_RES_NONE
	} fesf_res_t;

	typedef enum logic [2:0] {
		FESF_ST_IDLE,
		FESF_ST_WR,
		FESF_ST_WREND,
		FESF_ST_RD,
		FESF_ST_RDEND,
		FESF_ST_EVAL
	} fesf_state_t;

endpackage

/* File: common/fesf_regs.svh */
// Functional notes
// - host polls erase status at an erasing, unprotected sector address.
// - poll bit may turn valid before lower bits; host re-reads before trusting.
// - overprogramming locks the algorithm; host sees fail and issues reset sequence.
// - host samples erase window bit before and after each extra sector erase; the controller never tests bit 3, it only returns it in RDATA.
// - after buffer abort reads 1 host issues the abort reset sequence.
// - host reads toggle twice, then checks time-limit bit and re-tests toggle.
`ifndef FESF_REGS_SVH
`define FESF_REGS_SVH

// ==========================================================
// register offsets
`define FESF_OFF_CTRL   12'h000
`define FESF_OFF_ADDR   12'h004
`define FESF_OFF_WDATA  12'h008
`define FESF_OFF_RDATA  12'h00c
`define FESF_OFF_STAT   12'h010

// ==========================================================
// field positions
`define FESF_CTRL_GO      0
`define FESF_CTRL_CMD_LO  1
`define FESF_CTRL_CMD_HI  2
`define FESF_CTRL_BUF     3
`define FESF_STAT_DONE    1
`define FESF_RESET_VAL    32'h0000_0000

// ==========================================================
// status bits on the flash data lines
`define FESF_BIT_POLL    7
`define FESF_BIT_TOGGLE  6
`define FESF_BIT_TLFAIL  5
`define FESF_BIT_WINDOW  3
`define FESF_BIT_STOGGLE 2
`define FESF_BIT_ABORT   1

// ==========================================================
// widths and timing
`define FESF_AW        21
`define FESF_DW        16
`define FESF_CNT_W     8
`define FESF_CLK_NS    5
`define FESF_T_ACC_NS  100
`define FESF_T_WP_NS   50
`define FESF_T_GAP_NS  20
`define FESF_SYNC_CYC  4
`define FESF_ACC_CYC   ((`FESF_T_ACC_NS + `FESF_CLK_NS - 1) / `FESF_CLK_NS)
`define FESF_WP_CYC    ((`FESF_T_WP_NS + `FESF_CLK_NS - 1) / `FESF_CLK_NS)
`define FESF_GAP_CYC   ((`FESF_T_GAP_NS + `FESF_CLK_NS - 1) / `FESF_CLK_NS)

`endif

/* File: hdl/fesf_pin_sync.sv */
`timescale 1ns/1ps
module fesf_pin_sync #(
	parameter int W = 16
) (
	input  wire logic         clk_sys,
	input  wire logic         rstN,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] pinStable
);

	logic [W-1:0] ff1_r;
	logic [W-1:0] ff2_r;
	logic [W-1:0] ff3_r;
	logic [W-1:0] stable_r;

	// ==========================================================
	// three stages, accept once stages two and three agree
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			ff1_r    <= '0;
			ff2_r    <= '0;
			ff3_r    <= '0;
			stable_r <= '0;
		end else begin
			ff1_r <= pinIn;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
			for (int i = 0; i < W; i++) begin
				if (ff2_r[i] == ff3_r[i]) begin
					stable_r[i] <= ff3_r[i];
				end
			end
		end
	end

	assign pinStable = stable_r;

endmodule // fesf_pin_sync

/* File: hdl/fesf_poll_ctrl.sv */
`timescale 1ns/1ps
`include "fesf_regs.svh"
module fesf_poll_ctrl
	import fesf_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic      [`FESF_AW-1:0]  flashAddr,
	output logic                      flashCeN,
	output logic                      flashOeN,
	output logic                      flashWeN,
	input  wire logic [`FESF_DW-1:0]  flashDqIn,
	output logic      [`FESF_DW-1:0]  flashDqOut,
	output logic                      flashDqOe
);

	localparam logic [`FESF_CNT_W-1:0] RD_END  = `FESF_CNT_W'(`FESF_ACC_CYC + `FESF_SYNC_CYC - 1);
	localparam logic [`FESF_CNT_W-1:0] WP_END  = `FESF_CNT_W'(`FESF_WP_CYC - 1);
	localparam logic [`FESF_CNT_W-1:0] GAP_END = `FESF_CNT_W'(`FESF_GAP_CYC - 1);

	logic                    rstMeta_r;
	logic                    rstN;
	logic [`FESF_DW-1:0]     dqStable;
	fesf_state_t             state_r;
	fesf_cmd_t               cmd_r;
	fesf_res_t               res_r;
	fesf_res_t               res_nxt;
	logic [`FESF_CNT_W-1:0]  cnt_r;
	logic                    bufMode_r;
	logic                    expPoll_r;
	logic                    havePrev_r;
	logic                    havePrev_nxt;
	logic                    dq5Seen_r;
	logic                    dq5Seen_nxt;
	logic                    finalRd_r;
	logic                    finalRd_nxt;
	logic [`FESF_DW-1:0]     prev_r;
	logic [`FESF_DW-1:0]     prev_nxt;
	logic [`FESF_DW-1:0]     sample_r;
	logic [`FESF_DW-1:0]     rdata_r;
	logic                    done_r;
	logic                    again;
	logic                    finish;
	logic [`FESF_AW-1:0]     addrReg_r;
	logic [`FESF_DW-1:0]     wdataReg_r;
	logic [`FESF_AW-1:0]     addrOut_r;
	logic [`FESF_DW-1:0]     dqOut_r;
	logic                    dqOe_r;
	logic                    ceN_r;
	logic                    oeN_r;
	logic                    weN_r;
	logic [31:0]             prdata_r;
	logic                    pready_r;
	logic                    pslverr_r;
	logic                    apbSetup;
	logic                    apbDone;
	logic                    mapped;
	logic [31:0]             rdMux;
	logic                    go;
	logic                    doneClr;
	fesf_cmd_t               goCmd;

	// ==========================================================
	// reset release
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rstMeta_r <= 1'b0;
			rstN      <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstN      <= rstMeta_r;
		end
	end

	fesf_pin_sync #(.W(`FESF_DW)) u_dq_sync (
		.clk_sys   (clk_sys),
		.rstN      (rstN),
		.pinIn     (flashDqIn),
		.pinStable (dqStable)
	);

	// ==========================================================
	// apb slave
	assign apbSetup = psel & ~penable;
	assign apbDone  = psel & penable & pready_r;
	assign goCmd    = fesf_cmd_t'(pwdata[`FESF_CTRL_CMD_HI:`FESF_CTRL_CMD_LO]);
	assign go       = apbDone & pwrite & ~pslverr_r & (paddr == `FESF_OFF_CTRL)
	                  & pwdata[`FESF_CTRL_GO] & (state_r == FESF_ST_IDLE);
	assign doneClr  = apbDone & pwrite & (paddr == `FESF_OFF_STAT) & pwdata[`FESF_STAT_DONE];

	always_comb begin
		mapped = 1'b1;
		rdMux  = `FESF_RESET_VAL;
		unique case (paddr)
			`FESF_OFF_CTRL:  rdMux = 32'({bufMode_r, cmd_r, 1'b0});
			`FESF_OFF_ADDR:  rdMux = 32'(addrReg_r);
			`FESF_OFF_WDATA: rdMux = 32'(wdataReg_r);
			`FESF_OFF_RDATA: rdMux = 32'(rdata_r);
			`FESF_OFF_STAT:  rdMux = 32'({res_r, done_r, (state_r != FESF_ST_IDLE)});
			default:         mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			prdata_r   <= `FESF_RESET_VAL;
			addrReg_r  <= '0;
			wdataReg_r <= '0;
		end else begin
			pready_r <= apbSetup;
			if (apbSetup) begin
				prdata_r  <= pwrite ? `FESF_RESET_VAL : rdMux;
				pslverr_r <= ~mapped;
			end else if (apbDone) begin
				pslverr_r <= 1'b0;
			end
			if (apbDone && pwrite && paddr == `FESF_OFF_ADDR) begin
				addrReg_r <= pwdata[`FESF_AW-1:0];
			end
			if (apbDone && pwrite && paddr == `FESF_OFF_WDATA) begin
				wdataReg_r <= pwdata[`FESF_DW-1:0];
			end
		end
	end

	// ==========================================================
	// poll decision
	always_comb begin
		again        = 1'b0;
		finish       = 1'b0;
		res_nxt      = res_r;
		prev_nxt     = prev_r;
		havePrev_nxt = havePrev_r;
		dq5Seen_nxt  = dq5Seen_r;
		finalRd_nxt  = finalRd_r;
		if (finalRd_r || cmd_r == FESF_CMD_READ || cmd_r == FESF_CMD_WRITE) begin
			finish = 1'b1;
		end else if (cmd_r == FESF_CMD_TOGGLE && !havePrev_r) begin
			prev_nxt     = sample_r;
			havePrev_nxt = 1'b1;
			again        = 1'b1;
		end else if ((cmd_r == FESF_CMD_TOGGLE &&
		              sample_r[`FESF_BIT_TOGGLE] == prev_r[`FESF_BIT_TOGGLE]) ||
		             (cmd_r == FESF_CMD_DPOLL &&
		              sample_r[`FESF_BIT_POLL] == expPoll_r)) begin
			res_nxt     = FESF_RES_OK;
			finalRd_nxt = 1'b1;
			again       = 1'b1;
		end else if (bufMode_r && sample_r[`FESF_BIT_ABORT]) begin
			res_nxt = FESF_RES_ABORT;
			finish  = 1'b1;
		end else if (dq5Seen_r) begin
			res_nxt = FESF_RES_FAIL;
			finish  = 1'b1;
		end else begin
			dq5Seen_nxt = sample_r[`FESF_BIT_TLFAIL];
			prev_nxt    = sample_r;
			again       = 1'b1;
		end
	end

	// ==========================================================
	// flash cycle sequencer
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			state_r    <= FESF_ST_IDLE;
			cmd_r      <= FESF_CMD_WRITE;
			res_r      <= FESF_RES_NONE;
			cnt_r      <= '0;
			bufMode_r  <= 1'b0;
			expPoll_r  <= 1'b0;
			havePrev_r <= 1'b0;
			dq5Seen_r  <= 1'b0;
			finalRd_r  <= 1'b0;
			prev_r     <= '0;
			sample_r   <= '0;
			rdata_r    <= '0;
			done_r     <= 1'b0;
			addrOut_r  <= '0;
			dqOut_r    <= '0;
			dqOe_r     <= 1'b0;
			ceN_r      <= 1'b1;
			oeN_r      <= 1'b1;
			weN_r      <= 1'b1;
		end else begin
			if (doneClr) begin
				done_r <= 1'b0;
			end
			unique case (state_r)
				FESF_ST_IDLE: begin
					if (go) begin
						cmd_r      <= goCmd;
						bufMode_r  <= pwdata[`FESF_CTRL_BUF];
						res_r      <= FESF_RES_NONE;
						addrOut_r  <= addrReg_r;
						dqOut_r    <= wdataReg_r;
						expPoll_r  <= wdataReg_r[`FESF_BIT_POLL];
						havePrev_r <= 1'b0;
						dq5Seen_r  <= 1'b0;
						finalRd_r  <= 1'b0;
						cnt_r      <= '0;
						ceN_r      <= 1'b0;
						if (goCmd == FESF_CMD_WRITE) begin
							weN_r   <= 1'b0;
							dqOe_r  <= 1'b1;
							state_r <= FESF_ST_WR;
						end else begin
							oeN_r   <= 1'b0;
							state_r <= FESF_ST_RD;
						end
					end
				end
				FESF_ST_WR: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == WP_END) begin
						weN_r   <= 1'b1;
						ceN_r   <= 1'b1;
						cnt_r   <= '0;
						state_r <= FESF_ST_WREND;
					end
				end
				FESF_ST_WREND: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == GAP_END) begin
						dqOe_r  <= 1'b0;
						res_r   <= FESF_RES_OK;
						done_r  <= 1'b1;
						state_r <= FESF_ST_IDLE;
					end
				end
				FESF_ST_RD: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == RD_END) begin
						sample_r <= dqStable;
						oeN_r    <= 1'b1;
						ceN_r    <= 1'b1;
						cnt_r    <= '0;
						state_r  <= FESF_ST_RDEND;
					end
				end
				FESF_ST_RDEND: begin
					cnt_r <= cnt_r + 1'b1;
					if (cnt_r == GAP_END) begin
						state_r <= FESF_ST_EVAL;
					end
				end
				FESF_ST_EVAL: begin
					prev_r     <= prev_nxt;
					havePrev_r <= havePrev_nxt;
					dq5Seen_r  <= dq5Seen_nxt;
					finalRd_r  <= finalRd_nxt;
					res_r      <= (cmd_r == FESF_CMD_READ) ? FESF_RES_OK : res_nxt;
					cnt_r      <= '0;
					if (again) begin
						ceN_r   <= 1'b0;
						oeN_r   <= 1'b0;
						state_r <= FESF_ST_RD;
					end else if (finish) begin
						// window bit visible in read data
						rdata_r <= sample_r;
						done_r  <= 1'b1;
						state_r <= FESF_ST_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// outputs
	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign flashAddr  = addrOut_r;
	assign flashCeN   = ceN_r;
	assign flashOeN   = oeN_r;
	assign flashWeN   = weN_r;
	assign flashDqOut = dqOut_r;
	assign flashDqOe  = dqOe_r;

endmodule // fesf_poll_ctrl

/* File: verif/fesf_flash_model.sv */
`timescale 1ns/1ps
module fesf_flash_model (
	input  wire logic        ceN,
	input  wire logic        oeN,
	input  wire logic        weN,
	input  wire logic [20:0] addr,
	input  wire logic [15:0] dIn,
	input  wire logic        isErase,
	input  wire logic [3:0]  busyLen,
	input  wire logic        failOn,
	input  wire logic        abortOn,
	input  wire logic        protOn,
	output logic      [15:0] dOut
);
	logic [15:0] mem [16];
	logic [15:0] lastData = 16'h0;
	logic [15:0] held = 16'h0;
	logic [15:0] word;
	logic [3:0]  lastAddr = 4'h0;
	logic [3:0]  wCnt = 4'h0;
	logic [3:0]  rCnt = 4'h0;
	logic        busy = 1'b0;
	logic        tgl = 1'b0;
	logic        failed = 1'b0;
	logic        armed = 1'b0;
	initial begin
		for (int i = 0; i < 16; i++)
			mem[i] = 16'hffff;
	end
	// ====================
	// write pulses
	always @(negedge weN)
		armed = 1'b1;
	// start on last pulse, lock cleared by command
	always @(posedge weN) begin
		if (armed && (failed || (abortOn && busy))) begin
			busy = 1'b0;
			failed = 1'b0;
			wCnt = 4'h0;
		end else if (armed && !busy) begin
			lastData = dIn;
			lastAddr = addr[3:0];
			wCnt = wCnt + 4'h1;
			if (wCnt == (isErase ? 4'h6 : 4'h4)) begin
				busy = 1'b1;
				rCnt = 4'h0;
				wCnt = 4'h0;
			end
		end
		armed = 1'b0;
	end
	// ====================
	// read strobes
	// each read while busy flips toggles, overrun flagged
	always @(posedge oeN) begin
		held = ~word;
		if (busy) begin
			tgl = ~tgl;
			rCnt = rCnt + 4'h1;
			failed = failOn;
			if (rCnt >= busyLen && !failOn && !abortOn) begin
				busy = 1'b0;
				for (int i = 0; i < 16; i++)
					if (!(protOn && (i >= 8 || (isErase && lastAddr[3]))) &&
					    (isErase || 4'(i) == lastAddr))
						mem[i] = isErase ? 16'hffff : lastData;
			end
		end
	end
	always_comb begin
		word = mem[addr[3:0]];
		if (busy) begin
			word[7] = isErase ? 1'b0 : ~lastData[7];
			word[6] = tgl;
			word[5] = failed;
			word[3] = isErase && rCnt > 4'h1;
			word[2] = isErase ? tgl : 1'b1;
			word[1] = abortOn;
		end
	end
	assign dOut = (!ceN && !oeN) ? word : held;
endmodule // fesf_flash_model

/* File: verif/fesf_poll_ctrl_props.sv */
`timescale 1ns/1ps
`include "fesf_regs.svh"
module fesf_checker (
	input wire logic                clk_sys,
	input wire logic                resetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pready,
	input wire logic [`FESF_AW-1:0] flashAddr,
	input wire logic                flashCeN,
	input wire logic                flashOeN,
	input wire logic                flashWeN,
	input wire logic                flashDqOe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	// ====================
	// bus answer
	property p_rdy_setup;
		psel && !penable |=> pready;
	endproperty
	a_rdy_setup: assert property (p_rdy_setup)
		else $error("no pready after setup");
	property p_rdy_once;
		pready |=> !pready;
	endproperty
	a_rdy_once: assert property (p_rdy_once)
		else $error("pready longer than one cycle");
	// ====================
	// flash strobes
	property p_we_pulse;
		$fell(flashWeN) |-> ##9 !flashWeN ##1 flashWeN;
	endproperty
	a_we_pulse: assert property (p_we_pulse)
		else $error("write pulse width wrong");
	property p_oe_pulse;
		$fell(flashOeN) |-> ##23 !flashOeN ##1 flashOeN;
	endproperty
	a_oe_pulse: assert property (p_oe_pulse)
		else $error("read strobe width wrong");
	property p_read_gap;
		$rose(flashOeN) |-> flashOeN [*4];
	endproperty
	a_read_gap: assert property (p_read_gap)
		else $error("reads too close");
	property p_dq_hold;
		$rose(flashWeN) |-> flashDqOe [*4] ##1 !flashDqOe;
	endproperty
	a_dq_hold: assert property (p_dq_hold)
		else $error("data drive tail wrong");
	property p_no_fight;
		!flashOeN |-> flashWeN && !flashDqOe;
	endproperty
	a_no_fight: assert property (p_no_fight)
		else $error("drive during read");
	property p_ce_strobe;
		!flashOeN || !flashWeN |-> !flashCeN;
	endproperty
	a_ce_strobe: assert property (p_ce_strobe)
		else $error("strobe without chip enable");
	property p_addr_hold;
		!flashOeN ##1 !flashOeN |-> $stable(flashAddr);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address moved in read");
	c_xfer: cover property (pready);
	c_write: cover property ($rose(flashWeN));
	c_read: cover property ($rose(flashOeN));
endmodule // fesf_checker

/* File: verif/test_flash_embedded_status_flags.sv */
`timescale 1ns/1ps
`include "fesf_regs.svh"
module test_flash_embedded_status_flags
	import fesf_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdv, stat;
	logic        pready, pslverr, errv, flashCeN, flashOeN, flashWeN, flashDqOe;
	logic [20:0] flashAddr;
	logic [15:0] flashDqIn, flashDqOut, mdlDq;
	logic        isErase = 1'b0;
	logic        failOn = 1'b0;
	logic        abortOn = 1'b0;
	logic        protOn = 1'b0;
	logic [3:0]  busyLen = 4'h3;
	int          bad_count = 0;
	int          checked = 0;
	always #2.5 clk_sys = ~clk_sys;
	fesf_poll_ctrl u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flashAddr(flashAddr), .flashCeN(flashCeN), .flashOeN(flashOeN),
		.flashWeN(flashWeN), .flashDqIn(flashDqIn), .flashDqOut(flashDqOut),
		.flashDqOe(flashDqOe));
	fesf_flash_model u_flash (.ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN),
		.addr(flashAddr), .dIn(flashDqIn), .isErase(isErase), .busyLen(busyLen),
		.failOn(failOn), .abortOn(abortOn), .protOn(protOn), .dOut(mdlDq));
	assign flashDqIn = flashDqOe ? flashDqOut : mdlDq;
	// ====================
	// shared tasks
	task automatic summarize;
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stuck;
		bad_count++;
		summarize();
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1)
			stuck();
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic op(input fesf_cmd_t c, input logic bm, input logic [20:0] a,
		input logic [15:0] d);
		int n = 0;
		apb(1'b1, `FESF_OFF_ADDR, {11'h0, a});
		apb(1'b1, `FESF_OFF_WDATA, {16'h0, d});
		apb(1'b1, `FESF_OFF_CTRL, {28'h0, bm, c, 1'b1});
		do
			apb(1'b0, `FESF_OFF_STAT, 32'h0);
		while (rdv[`FESF_STAT_DONE] !== 1'b1 && ++n < 3000);
		if (n >= 3000)
			stuck();
		stat = rdv;
		apb(1'b1, `FESF_OFF_STAT, 32'h2);
	endtask
	// ====================
	// scenarios
	task automatic t_regs;
		apb(1'b0, `FESF_OFF_CTRL, 32'h0);
		chk(rdv, `FESF_RESET_VAL);
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, errv}, 32'h1);
		chk(rdv, 32'h0);
	endtask
	task automatic t_prog(input logic [20:0] a, input logic [15:0] d, input fesf_cmd_t pc);
		isErase <= 1'b0;
		for (int k = 0; k < 4; k++)
			op(FESF_CMD_WRITE, 1'b0, a, d);
		op(pc, 1'b0, a, d);
		chk(stat & 32'hd, 32'h0);
		apb(1'b0, `FESF_OFF_RDATA, 32'h0);
		chk(rdv, {16'h0, d});
	endtask
	task automatic t_erase;
		isErase <= 1'b1;
		for (int k = 0; k < 6; k++)
			op(FESF_CMD_WRITE, 1'b0, 21'h1, 16'h0080);
		op(FESF_CMD_DPOLL, 1'b0, 21'h1, 16'h0080);
		chk(stat & 32'hd, 32'h0);
		apb(1'b0, `FESF_OFF_RDATA, 32'h0);
		chk(rdv, 32'hffff);
	endtask
	task automatic t_bad(input logic f);
		isErase <= 1'b0;
		failOn <= f;
		abortOn <= ~f;
		for (int k = 0; k < 4; k++)
			op(FESF_CMD_WRITE, 1'b0, 21'h3, 16'h1234);
		op(FESF_CMD_TOGGLE, 1'b1, 21'h3, 16'h1234);
		chk(stat & 32'hd, f ? 32'h4 : 32'h8);
		op(FESF_CMD_WRITE, 1'b0, 21'h3, 16'h00f0);
		failOn <= 1'b0;
		abortOn <= 1'b0;
		op(FESF_CMD_READ, 1'b0, 21'h3, 16'h0);
		apb(1'b0, `FESF_OFF_RDATA, 32'h0);
		chk(rdv, 32'hffff);
	endtask
	task automatic t_prot;
		isErase <= 1'b0;
		for (int k = 0; k < 4; k++)
			op(FESF_CMD_WRITE, 1'b0, 21'h9, 16'h0a5a);
		op(FESF_CMD_TOGGLE, 1'b0, 21'h9, 16'h0a5a);
		protOn <= 1'b1;
		for (int k = 0; k < 4; k++)
			op(FESF_CMD_WRITE, 1'b0, 21'ha, 16'h1234);
		op(FESF_CMD_TOGGLE, 1'b0, 21'ha, 16'h1234);
		chk(stat & 32'hd, 32'h0);
		apb(1'b0, `FESF_OFF_RDATA, 32'h0);
		chk(rdv, 32'hffff);
		isErase <= 1'b1;
		for (int k = 0; k < 6; k++)
			op(FESF_CMD_WRITE, 1'b0, 21'h9, 16'h0080);
		op(FESF_CMD_TOGGLE, 1'b0, 21'h9, 16'h0080);
		apb(1'b0, `FESF_OFF_RDATA, 32'h0);
		chk(rdv, 32'h0a5a);
		for (int k = 0; k < 6; k++)
			op(FESF_CMD_WRITE, 1'b0, 21'h1, 16'h0080);
		op(FESF_CMD_DPOLL, 1'b0, 21'h1, 16'h0080);
		chk(stat & 32'hd, 32'h0);
		op(FESF_CMD_READ, 1'b0, 21'h9, 16'h0);
		apb(1'b0, `FESF_OFF_RDATA, 32'h0);
		chk(rdv, 32'h0a5a);
		protOn <= 1'b0;
		isErase <= 1'b0;
	endtask
	// ====================
	// main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_regs();
		t_prog(21'h1, 16'h5a3c, FESF_CMD_TOGGLE);
		t_prog(21'h2, 16'h00c3, FESF_CMD_DPOLL);
		t_erase();
		t_bad(1'b1);
		t_bad(1'b0);
		t_prot();
		summarize();
	end
endmodule // test_flash_embedded_status_flags
bind fesf_poll_ctrl fesf_checker u_chk (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
	.penable(penable), .pready(pready), .flashAddr(flashAddr), .flashCeN(flashCeN),
	.flashOeN(flashOeN),
	.flashWeN(flashWeN), .flashDqOe(flashDqOe));
